// File: hw/sfc_regs.vh
/*
  Register map, field positions, reset values and link timing of the
  serial-flash command and DMA controller.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SFC_REGS_VH
`define SFC_REGS_VH

`define SFC_ADDR_TRANS_CTRL  32'h40012004
`define SFC_ADDR_READ_CTRL   32'h40012008
`define SFC_ADDR_CMD_LOW     32'h4001200C
`define SFC_ADDR_CMD_HIGH    32'h40012010
`define SFC_ADDR_DIRECTION   32'h40012014
`define SFC_ADDR_FLAGS       32'h40012018
`define SFC_ADDR_BUF_START   32'h4001201C
`define SFC_ADDR_OPTIONS     32'h40012020

`define SFC_RST_TRANS_CTRL   32'h00000004
`define SFC_RST_READ_CTRL    24'h000000
`define SFC_RST_CMD          32'h00000000
`define SFC_RST_DIRECTION    8'h0F
`define SFC_RST_BUF_START    32'h00000000
`define SFC_RST_OPTIONS      9'h103

`define SFC_GO_BIT           7
`define SFC_FLAG_DONE_BIT    0
`define SFC_FLAG_ERR_BIT     1
`define SFC_OPT_ENDIAN_BIT   0
`define SFC_OPT_CMD_LSB_BIT  1
`define SFC_OPT_RD_REV_BIT   2
`define SFC_OPT_STAT_REV_BIT 3
`define SFC_OPT_WR_LSB_BIT   8

`define SFC_SCK_HALF_CYCLES  4

`endif

// File: hw/sfc_shift.v
/*
  One-byte serial shifter, clock mode 0: drives the serial clock and data
  out, samples the data in on each rising serial clock edge.
  Assumes miso_s is already synchronised to clk and HALF is at least 3, so
  that the synchroniser delay stays inside one half period.
*/
`timescale 1ns/100ps
module sfc_shift #(
  parameter HALF = 4
) (
  input  wire       clk,
  input  wire       reset,
  input  wire       start,
  input  wire [7:0] tx,
  input  wire       lsb_first,
  input  wire       miso_s,
  output reg        sck_q,
  output wire       mosi,
  output reg        done_q,
  output reg  [7:0] rx_q
);
  reg [7:0] cnt_q;
  reg [2:0] bit_q;
  reg       act_q;
  reg [7:0] tx_q;
  integer   i;
  reg [7:0] tx_rev;

  always @* begin
    tx_rev = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      tx_rev[i] = tx[7 - i];
    end
  end

  // Always shifts out of bit 7; LSB-first is a reversal at load
  assign mosi = tx_q[7];

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q  <= 8'h00;
      bit_q  <= 3'h0;
      act_q  <= 1'b0;
      sck_q  <= 1'b0;
      tx_q   <= 8'h00;
      rx_q   <= 8'h00;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        act_q <= 1'b1;
        tx_q  <= lsb_first ? tx_rev : tx;
        cnt_q <= 8'h00;
        bit_q <= 3'h0;
        sck_q <= 1'b0;
      end else if (act_q) begin
        if (cnt_q == HALF - 1) begin
          cnt_q <= 8'h00;
          if (!sck_q) begin
            sck_q <= 1'b1;
            rx_q  <= {rx_q[6:0], miso_s};
          end else begin
            sck_q <= 1'b0;
            tx_q  <= {tx_q[6:0], 1'b0};
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              act_q  <= 1'b0;
              done_q <= 1'b1;
            end
          end
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end
endmodule // sfc_shift

// File: hw/sfc_top.v
/*
  Serial-flash controller core: command buffer with per-byte direction,
  done and bus-error flags, DMA between flash and an application buffer,
  bit-order and byte-order options.
  Assumes a single-cycle register port, a request/acknowledge word bus
  towards system memory and one serial flash on the four link pins.
*/
// Strobed register access is this design's own decision.
// Functional notes
// RQ1: low command word holds bytes one to four
// RQ2: high command word holds bytes five to eight
// RQ3: direction bit per byte, resets 0x0F
// RQ4: bus error response sets error flag bit1
// RQ5: transaction completion sets done flag bit0
// RQ6: flags clear on read or zero write
// RQ7: DMA uses buffer start address, reset zero
// RQ8: option bit8 selects write data bit order
// RQ9: software leaves debug option bits untouched
// RQ10: option bit3 reverses captured status bytes
// RQ11: option bit2 reverses read data bytes
// RQ12: option bit1 selects command byte bit order
// RQ13: option bit0 selects data byte order
// RQ14: options reset to 0x0103
// RQ15: go bit starts, clears at completion
// RQ16: command count clears at completion
// RQ17: write count clears at completion
// RQ18: read count clears at completion
// RQ19: commands, then data, then done flag
// RQ20: received command bytes captured into buffer
`timescale 1ns/100ps
`include "sfc_regs.vh"
module sfc_top #(
  parameter SCK_HALF = `SFC_SCK_HALF_CYCLES
) (
  input  wire        clk,
  input  wire        reset,
  input  wire [31:0] reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  output reg         dma_req,
  output reg         dma_we,
  output reg  [31:0] dma_addr,
  output reg  [31:0] dma_wdata,
  input  wire [31:0] dma_rdata,
  input  wire        dma_ack,
  input  wire        dma_err,
  output wire        flash_sck,
  output reg         flash_csn,
  output wire        flash_mosi,
  input  wire        flash_miso,
  output wire        busy
);
  localparam S_IDLE   = 4'd0;
  localparam S_CMD    = 4'd1;
  localparam S_CWAIT  = 4'd2;
  localparam S_WFETCH = 4'd3;
  localparam S_WSEND  = 4'd4;
  localparam S_WWAIT  = 4'd5;
  localparam S_RSEND  = 4'd6;
  localparam S_RWAIT  = 4'd7;
  localparam S_RSTORE = 4'd8;
  localparam S_DONE   = 4'd9;
  // Reset fields of the transaction control word, taken from one constant
  localparam [31:0] RST_TRANS = `SFC_RST_TRANS_CTRL;

  reg  [63:0] cmd_q;
  reg  [7:0]  dir_q;
  reg  [31:0] start_q;
  reg  [8:0]  opt_q;
  reg         go_q;
  reg  [2:0]  cmd_n_q;
  reg  [23:0] wn_q;
  reg  [23:0] rn_q;
  reg         done_flag_q;
  reg         err_flag_q;
  reg  [3:0]  state_q;
  reg  [2:0]  cmd_idx_q;
  reg  [23:0] byte_idx_q;
  reg  [31:0] word_q;
  reg         sh_start_q;
  reg  [7:0]  sh_tx_q;
  reg         sh_lsb_q;
  reg         miso_meta_q;
  reg         miso_s_q;
  reg  [31:0] rd_mux;

  wire        sh_done;
  wire [7:0]  sh_rx;
  wire        flag_rd = reg_rd && (reg_addr == `SFC_ADDR_FLAGS);
  wire        flag_wr = reg_wr && (reg_addr == `SFC_ADDR_FLAGS);
  wire        idle    = (state_q == S_IDLE);
  wire [23:0] idx_nx  = byte_idx_q + 24'h000001;
  wire        cmd_tx  = dir_q[cmd_idx_q];
  wire [5:0]  cmd_sel = {cmd_idx_q, 3'b000};
  // Little-endian sends bits 7:0 of each word first
  wire [1:0]  lane    = opt_q[`SFC_OPT_ENDIAN_BIT] ? byte_idx_q[1:0] : ~byte_idx_q[1:0]; // RQ13
  wire [4:0]  lane_sel = {lane, 3'b000};
  // Low start-address bits are added as they are: keep the buffer word aligned
  wire [31:0] word_addr = start_q + {8'h00, byte_idx_q[23:2], 2'b00}; // RQ7
  wire        err_set = dma_req && dma_ack && dma_err;
  wire        done_set = (state_q == S_DONE);

  function [7:0] rev8;
    input [7:0] b;
    integer k;
    begin
      rev8 = 8'h00;
      for (k = 0; k < 8; k = k + 1) begin
        rev8[k] = b[7 - k];
      end
    end
  endfunction

  // Busy drops in the same cycle that the done flag rises
  assign busy = !idle;

  sfc_shift #(
    .HALF (SCK_HALF)
  ) u_shift (
    .clk       (clk),
    .reset     (reset),
    .start     (sh_start_q),
    .tx        (sh_tx_q),
    .lsb_first (sh_lsb_q),
    .miso_s    (miso_s_q),
    .sck_q     (flash_sck),
    .mosi      (flash_mosi),
    .done_q    (sh_done),
    .rx_q      (sh_rx)
  );

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      miso_meta_q <= 1'b0;
      miso_s_q    <= 1'b0;
    end else begin
      miso_meta_q <= flash_miso;
      miso_s_q    <= miso_meta_q;
    end
  end

  always @* begin
    rd_mux = 32'h00000000;
    case (reg_addr)
      `SFC_ADDR_TRANS_CTRL: rd_mux = {wn_q, go_q, 4'h0, cmd_n_q};
      `SFC_ADDR_READ_CTRL:  rd_mux = {8'h00, rn_q};
      `SFC_ADDR_CMD_LOW:    rd_mux = cmd_q[31:0];
      `SFC_ADDR_CMD_HIGH:   rd_mux = cmd_q[63:32];
      `SFC_ADDR_DIRECTION:  rd_mux = {24'h000000, dir_q};
      `SFC_ADDR_FLAGS:      rd_mux = {30'h00000000, err_flag_q, done_flag_q};
      `SFC_ADDR_BUF_START:  rd_mux = start_q;
      `SFC_ADDR_OPTIONS:    rd_mux = {23'h000000, opt_q};
      default:              rd_mux = 32'h00000000;
    endcase
  end

  // Flags are sticky; a hardware set wins over a clear in the same cycle
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      done_flag_q <= 1'b0;
      err_flag_q  <= 1'b0;
    end else begin
      if (done_set) begin
        done_flag_q <= 1'b1; // RQ5
      end else if (flag_rd || (flag_wr && !reg_wdata[`SFC_FLAG_DONE_BIT])) begin
        done_flag_q <= 1'b0; // RQ6
      end
      if (err_set) begin
        err_flag_q <= 1'b1; // RQ4
      end else if (flag_rd || (flag_wr && !reg_wdata[`SFC_FLAG_ERR_BIT])) begin
        err_flag_q <= 1'b0; // RQ6
      end
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata   <= 32'h00000000;
      cmd_q       <= {`SFC_RST_CMD, `SFC_RST_CMD};
      dir_q       <= `SFC_RST_DIRECTION; // RQ3
      start_q     <= `SFC_RST_BUF_START;
      opt_q       <= `SFC_RST_OPTIONS; // RQ14
      go_q        <= RST_TRANS[`SFC_GO_BIT];
      cmd_n_q     <= RST_TRANS[2:0];
      wn_q        <= RST_TRANS[31:8];
      rn_q        <= `SFC_RST_READ_CTRL;
      state_q     <= S_IDLE;
      cmd_idx_q   <= 3'h0;
      byte_idx_q  <= 24'h000000;
      word_q      <= 32'h00000000;
      sh_start_q  <= 1'b0;
      sh_tx_q     <= 8'h00;
      sh_lsb_q    <= 1'b0;
      flash_csn   <= 1'b1;
      dma_req     <= 1'b0;
      dma_we      <= 1'b0;
      dma_addr    <= 32'h00000000;
      dma_wdata   <= 32'h00000000;
    end else begin
      // Read data stand for one cycle only and are zero otherwise
      reg_rdata  <= reg_rd ? rd_mux : 32'h00000000;
      sh_start_q <= 1'b0;
      // Counts and buffers ignore register writes while a transaction runs
      if (reg_wr && idle) begin
        case (reg_addr)
          `SFC_ADDR_TRANS_CTRL: begin
            wn_q    <= reg_wdata[31:8];
            go_q    <= reg_wdata[`SFC_GO_BIT]; // RQ15
            cmd_n_q <= reg_wdata[2:0];
          end
          `SFC_ADDR_READ_CTRL: rn_q <= reg_wdata[23:0];
          `SFC_ADDR_CMD_LOW:   cmd_q[31:0] <= reg_wdata; // RQ1
          `SFC_ADDR_CMD_HIGH:  cmd_q[63:32] <= reg_wdata; // RQ2
          `SFC_ADDR_DIRECTION: dir_q <= reg_wdata[7:0];
          `SFC_ADDR_BUF_START: start_q <= reg_wdata;
          // Bits 7:4 are kept as written and steer nothing
          `SFC_ADDR_OPTIONS:   opt_q <= reg_wdata[8:0]; // RQ9
          default: ;
        endcase
      end
      case (state_q)
        S_IDLE: begin
          if (go_q) begin
            flash_csn  <= 1'b0;
            cmd_idx_q  <= 3'h0;
            byte_idx_q <= 24'h000000;
            word_q     <= 32'h00000000;
            if (cmd_n_q != 3'h0) begin
              state_q <= S_CMD; // RQ19
            end else if (wn_q != 24'h000000) begin
              state_q <= S_WFETCH;
            end else if (rn_q != 24'h000000) begin
              state_q <= S_RSEND;
            end else begin
              state_q <= S_DONE;
            end
          end
        end
        S_CMD: begin
          // A received byte clocks out zeros while listening
          sh_tx_q    <= cmd_tx ? cmd_q[cmd_sel +: 8] : 8'h00;
          sh_lsb_q   <= opt_q[`SFC_OPT_CMD_LSB_BIT]; // RQ12
          sh_start_q <= 1'b1;
          state_q    <= S_CWAIT;
        end
        S_CWAIT: begin
          if (sh_done) begin
            if (!cmd_tx) begin
              cmd_q[cmd_sel +: 8] <= opt_q[`SFC_OPT_STAT_REV_BIT] ? rev8(sh_rx) : sh_rx; // RQ20 RQ10
            end
            cmd_idx_q <= cmd_idx_q + 3'h1;
            if (cmd_idx_q + 3'h1 != cmd_n_q) begin
              state_q <= S_CMD; // RQ19
            end else if (wn_q != 24'h000000) begin
              state_q <= S_WFETCH;
            end else if (rn_q != 24'h000000) begin
              state_q <= S_RSEND;
            end else begin
              state_q <= S_DONE;
            end
          end
        end
        S_WFETCH: begin
          // The request holds until the slave acknowledges it
          if (dma_req && dma_ack) begin
            dma_req <= 1'b0;
            word_q  <= dma_rdata;
            state_q <= S_WSEND;
          end else begin
            dma_req  <= 1'b1;
            dma_we   <= 1'b0;
            dma_addr <= word_addr; // RQ7
          end
        end
        S_WSEND: begin
          sh_tx_q    <= word_q[lane_sel +: 8]; // RQ13
          sh_lsb_q   <= opt_q[`SFC_OPT_WR_LSB_BIT]; // RQ8
          sh_start_q <= 1'b1;
          state_q    <= S_WWAIT;
        end
        S_WWAIT: begin
          if (sh_done) begin
            byte_idx_q <= idx_nx;
            if (idx_nx == wn_q) begin
              byte_idx_q <= 24'h000000;
              word_q     <= 32'h00000000;
              state_q    <= (rn_q != 24'h000000) ? S_RSEND : S_DONE; // RQ19
            end else if (byte_idx_q[1:0] == 2'b11) begin
              state_q <= S_WFETCH;
            end else begin
              state_q <= S_WSEND;
            end
          end
        end
        S_RSEND: begin
          // Read bytes clock out zeros while listening
          sh_tx_q    <= 8'h00;
          sh_lsb_q   <= 1'b0;
          sh_start_q <= 1'b1;
          state_q    <= S_RWAIT;
        end
        S_RWAIT: begin
          if (sh_done) begin
            word_q[lane_sel +: 8] <= opt_q[`SFC_OPT_RD_REV_BIT] ? rev8(sh_rx) : sh_rx; // RQ11 RQ13
            if ((idx_nx == rn_q) || (byte_idx_q[1:0] == 2'b11)) begin
              state_q <= S_RSTORE;
            end else begin
              byte_idx_q <= idx_nx;
              state_q    <= S_RSEND;
            end
          end
        end
        S_RSTORE: begin
          // A short last word goes out with its unused lanes at zero
          if (dma_req && dma_ack) begin
            dma_req    <= 1'b0;
            dma_we     <= 1'b0;
            word_q     <= 32'h00000000;
            byte_idx_q <= idx_nx;
            state_q    <= (idx_nx == rn_q) ? S_DONE : S_RSEND;
          end else begin
            dma_req   <= 1'b1;
            dma_we    <= 1'b1;
            dma_addr  <= word_addr; // RQ7
            dma_wdata <= word_q;
          end
        end
        S_DONE: begin
          // Counts clear so that a stray go cannot replay the last job
          flash_csn <= 1'b1;
          go_q      <= 1'b0; // RQ15
          cmd_n_q   <= 3'h0; // RQ16
          wn_q      <= 24'h000000; // RQ17
          rn_q      <= 24'h000000; // RQ18
          state_q   <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule // sfc_top

// File: tb/sfc_flash_model.sv
/*
  Behavioural serial flash: answers byte j of every frame with a counted
  pattern, most significant bit first.
  Assumes clock mode 0 and a select that stays low for the whole frame.
*/
`timescale 1ns/100ps
module sfc_flash_model (
  input  wire csn,
  input  wire sck,
  output reg  miso
);
  reg [7:0] sh;
  int       n;
  int       j;
  initial miso = 1'b0;
  always @(negedge csn) begin
    j = 0;
    n = 0;
    sh = 8'(j * 37 + 150);
    miso = sh[7];
  end
  always @(posedge sck) n = n + 1;
  // Changing on the falling edge gives the synchroniser a full half period
  always @(negedge sck) if (!csn) begin
    if (n == 8) begin
      j = j + 1;
      n = 0;
      sh = 8'(j * 37 + 150);
    end else sh = {sh[6:0], 1'b0};
    miso = sh[7];
  end
  // Released line: no pull, so show the opposite level
  always @(posedge csn) miso = ~miso;
endmodule // sfc_flash_model

// File: tb/sfc_monitor.sv
/*
  Checker for the flash controller core: register read slot, flags,
  serial clock framing and the memory-side request handshake.
  Assumes it is bound to sfc_top and sees only its ports.
*/
`timescale 1ns/100ps
`include "sfc_regs.vh"
module sfc_monitor #(
  parameter SCK_HALF = 4
) (
  input wire        clk,
  input wire        reset,
  input wire [31:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        dma_req,
  input wire        dma_we,
  input wire [31:0] dma_addr,
  input wire [31:0] dma_wdata,
  input wire [31:0] dma_rdata,
  input wire        dma_ack,
  input wire        dma_err,
  input wire        flash_sck,
  input wire        flash_csn,
  input wire        flash_mosi,
  input wire        flash_miso,
  input wire        busy
);
  logic [7:0] hi_n;
  logic       err_s;
  logic       done_s;
  logic       csn_d;
  // The controller sets the done flag at the edge that raises the select
  wire        csn_rise = flash_csn & ~csn_d;
  wire        done_now = done_s | csn_rise;
  wire        flag_clr = (reg_rd || (reg_wr && !reg_wdata[0])) && reg_addr == `SFC_ADDR_FLAGS;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence go_wr;
    reg_wr && reg_addr == `SFC_ADDR_TRANS_CTRL && reg_wdata[`SFC_GO_BIT] && !busy;
  endsequence
  sequence rd_flags;
    reg_rd && reg_addr == `SFC_ADDR_FLAGS;
  endsequence
  // Shadow flags: a read or zero write clears, a hardware set wins
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      hi_n   <= 8'h00;
      err_s  <= 1'b0;
      done_s <= 1'b0;
      csn_d  <= 1'b1;
    end else begin
      hi_n  <= flash_sck ? hi_n + 8'h01 : 8'h00;
      csn_d <= flash_csn;
      if (reg_rd && reg_addr == `SFC_ADDR_FLAGS) begin
        err_s  <= 1'b0;
        done_s <= 1'b0;
      end else if (reg_wr && reg_addr == `SFC_ADDR_FLAGS) begin
        err_s  <= err_s & reg_wdata[1];
        done_s <= done_s & reg_wdata[0];
      end
      // The set seen here happened one edge ago, so only a clear now undoes it
      if (csn_rise) done_s <= !flag_clr;
      if (dma_req && dma_ack && dma_err) err_s <= 1'b1;
    end
  end
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  flags_val_a: assert property (rd_flags |=> reg_rdata == {30'h0, $past(err_s), $past(done_now)})
    else $error("flag read value wrong");
  opt_high_a: assert property (reg_rd && reg_addr == `SFC_ADDR_OPTIONS |=> reg_rdata[31:9] == 23'h0)
    else $error("option upper bits not zero");
  go_start_a: assert property (go_wr |-> ##[1:3] (!flash_csn && busy))
    else $error("transaction did not start");
  sck_idle_a: assert property (flash_csn |-> !flash_sck)
    else $error("serial clock outside frame");
  sck_high_a: assert property ($fell(flash_sck) |-> hi_n == SCK_HALF)
    else $error("serial clock high time wrong");
  mosi_hold_a: assert property (flash_sck |-> $stable(flash_mosi))
    else $error("data out moved while clock high");
  dma_hold_a: assert property (dma_req && !dma_ack |=> dma_req && $stable(dma_addr) && $stable(dma_wdata))
    else $error("bus request not held");
  dma_drop_a: assert property (dma_ack |=> !dma_req)
    else $error("bus request held after ack");
  dma_frame_a: assert property (dma_req |-> busy)
    else $error("bus request while idle");
endmodule // sfc_monitor

bind sfc_top sfc_monitor #(.SCK_HALF(SCK_HALF)) mon (.clk(clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_req(dma_req),
  .dma_we(dma_we), .dma_addr(dma_addr), .dma_wdata(dma_wdata), .dma_rdata(dma_rdata), .dma_ack(dma_ack),
  .dma_err(dma_err), .flash_sck(flash_sck), .flash_csn(flash_csn), .flash_mosi(flash_mosi),
  .flash_miso(flash_miso), .busy(busy));

// File: tb/tb.sv
/*
  Self-checking bench for the flash controller core.
  Assumes the flash model on the link and a memory slave kept here.
*/
`timescale 1ns/100ps
`include "sfc_regs.vh"
module tb;
  logic        clk, reset, reg_wr, reg_rd, dma_ack, dma_err, err_on;
  logic [31:0] reg_addr, reg_wdata, dma_rdata, st, lo, hi, w, mw[2], rq[$], aq[$], wq[$];
  wire  [31:0] reg_rdata, dma_addr, dma_wdata;
  wire         dma_req, dma_we, flash_sck, flash_csn, flash_mosi, flash_miso, busy;
  logic [7:0]  fq[$], sb, b;
  logic [8:0]  op;
  bit          rd_d;
  int          fail_count, n_compared, nb, i, k, cc, dly;
  sfc_top uut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_req(dma_req), .dma_we(dma_we), .dma_addr(dma_addr),
    .dma_wdata(dma_wdata), .dma_rdata(dma_rdata), .dma_ack(dma_ack), .dma_err(dma_err), .flash_sck(flash_sck),
    .flash_csn(flash_csn), .flash_mosi(flash_mosi), .flash_miso(flash_miso), .busy(busy));
  sfc_flash_model fl (.csn(flash_csn), .sck(flash_sck), .miso(flash_miso));
  function automatic logic [7:0] rv(input logic [7:0] x);
    for (int q = 0; q < 8; q++) rv[q] = x[7-q];
  endfunction
  task automatic chk(input [31:0] g, input [31:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic summarize;
    if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input [31:0] a, input [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input [31:0] a, input [31:0] e);
    rq.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rd_d) chk(reg_rdata, rq.pop_front());
    rd_d <= reg_rd;
  end
  // Bytes on the wire, sampled on the rising serial clock edge
  always @(negedge flash_csn) nb = 0;
  always @(posedge flash_sck) begin
    sb = {sb[6:0], flash_mosi};
    nb++;
    if (nb == 8 && fq.size() > 0) chk({24'h0, sb}, {24'h0, fq.pop_front()});
    if (nb == 8) nb = 0;
  end
  // Memory slave with a random wait; idle data lines keep changing
  always @(posedge clk) begin
    if (dma_req && !dma_ack && dly == 0) begin
      dma_ack <= 1'b1;
      dma_err <= err_on;
      err_on <= 1'b0;
      dly <= $urandom % 4;
      dma_rdata <= mw[dma_addr[2] ^ st[2]];
      if (dma_we) chk(dma_wdata, wq.pop_front());
      chk(dma_addr, aq.pop_front());
    end else begin
      dma_ack <= 1'b0;
      dma_err <= 1'($urandom);
      dma_rdata <= $urandom;
      if (dma_req && dly > 0) dly <= dly - 1;
    end
  end
  initial begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 32'h0;
    reg_wdata = 32'h0;
    dma_ack = 1'b0;
    dma_err = 1'b0;
    dma_rdata = 32'h0;
    err_on = 1'b0;
    void'($urandom(91606));
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(`SFC_ADDR_TRANS_CTRL, 32'h4);
    rd(`SFC_ADDR_READ_CTRL, 32'h0);
    rd(`SFC_ADDR_CMD_LOW, 32'h0);
    rd(`SFC_ADDR_CMD_HIGH, 32'h0);
    rd(`SFC_ADDR_DIRECTION, 32'hF);
    rd(`SFC_ADDR_FLAGS, 32'h0);
    rd(`SFC_ADDR_BUF_START, 32'h0);
    rd(`SFC_ADDR_OPTIONS, 32'h103);
    rd(32'h40012000, 32'h0);
    for (i = 0; i < 4; i++) begin
      cc = (i == 3) ? 7 : 2;
      op = {i[0] ^ i[1], 4'h0, i[0], i[1], i[1], i[0]};
      lo = $urandom;
      hi = $urandom;
      st = $urandom & 32'hFFFFFFFC;
      mw[0] = $urandom;
      mw[1] = $urandom;
      err_on = i[1];
      aq.push_back(st);
      aq.push_back(st + 4);
      aq.push_back(st);
      for (k = 0; k < cc; k++) begin
        b = k < 4 ? lo[8*k +: 8] : hi[8*(k-4) +: 8];
        fq.push_back(k == 1 ? 8'h00 : op[1] ? rv(b) : b);
      end
      for (k = 0; k < 5; k++) begin
        w = mw[k/4];
        b = op[0] ? w[8*(k%4) +: 8] : w[31-8*(k%4) -: 8];
        fq.push_back(op[8] ? rv(b) : b);
      end
      w = 32'h0;
      for (k = 0; k < 3; k++) begin
        fq.push_back(8'h00);
        b = 8'((cc + 5 + k) * 37 + 150);
        b = op[2] ? rv(b) : b;
        if (op[0]) w[8*k +: 8] = b;
        else w[31-8*k -: 8] = b;
      end
      wq.push_back(w);
      b = op[3] ? rv(8'(187)) : 8'(187);
      wr(`SFC_ADDR_OPTIONS, {16'h0, 7'h7F, op});
      wr(`SFC_ADDR_CMD_LOW, lo);
      wr(`SFC_ADDR_CMD_HIGH, hi);
      wr(`SFC_ADDR_DIRECTION, 32'hFFFFFFFD);
      wr(`SFC_ADDR_BUF_START, st);
      wr(`SFC_ADDR_READ_CTRL, 32'h3);
      wr(`SFC_ADDR_TRANS_CTRL, 32'h580 | cc);
      repeat (3) @(posedge clk);
      wr(`SFC_ADDR_BUF_START, ~st);
      for (k = 0; k < 5000 && busy !== 1'b0; k++) @(posedge clk);
      if (k == 5000) begin
        fail_count++;
        summarize;
      end
      rd(`SFC_ADDR_TRANS_CTRL, 32'h0);
      rd(`SFC_ADDR_READ_CTRL, 32'h0);
      rd(`SFC_ADDR_CMD_LOW, {lo[31:16], b, lo[7:0]});
      rd(`SFC_ADDR_CMD_HIGH, hi);
      rd(`SFC_ADDR_DIRECTION, 32'hFD);
      rd(`SFC_ADDR_BUF_START, st);
      rd(`SFC_ADDR_OPTIONS, {23'h0, op});
      if (i[0]) wr(`SFC_ADDR_FLAGS, 32'h2);
      rd(`SFC_ADDR_FLAGS, {30'h0, i[1], ~i[0]});
      rd(`SFC_ADDR_FLAGS, 32'h0);
    end
    @(posedge clk);
    chk(fq.size() + aq.size() + wq.size(), 32'h0);
    summarize;
  end
endmodule // tb
